// [dds_ctl_pkg.sv]
// package: field positions, destination codes, reset values and widths for control word one
package dds_ctl_pkg;
   localparam int word_w = 32;
   localparam int dest_hi = 13;
   localparam int dest_lo = 12;
   localparam int acc_en_bit = 11;
   localparam int dc_out_bit = 10;
   localparam int state_trig_bit = 9;
   localparam int no_dwell_bit = 8;
   localparam int ext_pd_mode_bit = 7;
   localparam int dig_pd_bit = 6;
   localparam int dac_pd_bit = 5;
   localparam int clk_pd_bit = 4;
   localparam int load_rate_bit = 3;
   localparam int aclr_aux_bit = 2;
   localparam int aclr_phase_bit = 1;
   localparam int sine_bit = 0;
   localparam logic [1:0] dest_freq = 2'h0;
   localparam logic [1:0] dest_phase = 2'h1;
   localparam logic [31:0] ctl_reset = 32'h0000_0000;
   localparam int rate_w = 16;
   localparam logic [15:0] rate_reset = 16'h0001;
endpackage : dds_ctl_pkg

// [pin_sync.sv]
// three-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module pin_sync
(
   input wire logic ref_clk, // system clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic pin_in, // asynchronous level
   output logic level_out // filtered level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_out <= 1'b0;
      end
      else
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // change accepted only when stages two and three agree
         if (s2_q == s3_q)
            level_out <= s3_q;
      end
   end
endmodule : pin_sync

// [rate_timer.sv]
// ramp rate timer: counts down, reloads on timeout or on forced load
`timescale 1ns/1ps
module rate_timer #(
   parameter int W = 16
)
(
   input wire logic ref_clk, // system clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic run, // count enable
   input wire logic force_load, // load new value at once
   input wire logic [W-1:0] rate, // active reload value
   output logic tick // one-cycle pulse on timeout
);
   logic [W-1:0] cnt_q;
   wire timeout = (cnt_q == '0);
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         cnt_q <= '0;
         tick <= 1'b0;
      end
      else
      begin
         tick <= run && timeout && !force_load;
         if (force_load)
            cnt_q <= rate;
         else if (run)
            cnt_q <= timeout ? rate : cnt_q - 1'b1;
      end
   end
endmodule : rate_timer

// [dds_ctl_word.sv]
// control word one: shadow and active copies, decode into core controls
// What this block does
// - destination 00 selects frequency switching or sweep
// - destination 01 selects phase switching or sweep
// - auxiliary accumulator runs only when enabled
// - dc output forces full scale during sweep
// - bit 9 picks edge or level trigger
// - no-dwell returns to start, else hold
// - fast power-down idles digital logic only
// - full power-down idles every function
// - digital power-down bit idles core
// - converter power-down bit disables converter
// - clock power-down stops clock generation
// - rate update waits for timer timeout
// - rate update on strobe reloads immediately
// - strobe clears auxiliary accumulator one cycle
// - strobe clears phase accumulator one cycle
// - bit 0 selects sine or cosine
// - written bits take effect on update strobe
`timescale 1ns/1ps
module dds_ctl_word #(
   parameter int RATE_W = dds_ctl_pkg::rate_w
)
(
   input wire logic ref_clk, // system clock, 200 MHz
   input wire logic rst_b, // synchronous reset, active low
   input wire logic wr_en, // io port write strobe for control word one
   input wire logic [31:0] wr_data, // io port write data
   output logic [31:0] rd_data, // io port read data, shadow copy
   input wire logic [RATE_W-1:0] sweep_rate_value, // written sweep rate value
   input wire logic io_update_pin, // update strobe pin, asynchronous
   input wire logic external_powerdown_pin, // external power-down pin, asynchronous
   input wire logic sweep_ctl_pin, // sweep trigger input, asynchronous
   input wire logic sweep_done, // core reports sweep end
   output logic [31:0] active_word, // active copy of control word one
   output logic freq_dest, // aux accumulator drives frequency
   output logic phase_dest, // aux accumulator drives phase
   output logic aux_acc_run, // aux accumulator running
   output logic dc_full_scale, // converter input forced to full scale
   output logic dds_out_off, // synthesized output disabled
   output logic sweep_trigger, // sweep advance request
   output logic sweep_to_start, // return sweep to initial value
   output logic sweep_hold, // hold sweep at final value
   output logic digital_pd, // digital logic powered down
   output logic dac_digital_pd, // converter digital logic powered down
   output logic dac_pd, // converter analog section powered down
   output logic pll_pd, // pll powered down
   output logic osc_pd, // oscillator and clock input powered down
   output logic clk_gen_stop, // all clock generation stopped
   output logic rate_tick, // ramp rate timer timeout pulse
   output logic aux_acc_clear, // aux accumulator load zero, one cycle
   output logic phase_acc_clear, // phase accumulator clear, one cycle
   output logic sine_sel // 1 sine, 0 cosine
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic upd_lvl;
   logic pd_lvl;
   logic trig_lvl;
   pin_sync u_upd (.ref_clk(ref_clk), .rst_b(rst_b), .pin_in(io_update_pin), .level_out(upd_lvl));
   pin_sync u_pd (.ref_clk(ref_clk), .rst_b(rst_b), .pin_in(external_powerdown_pin), .level_out(pd_lvl));
   pin_sync u_trig (.ref_clk(ref_clk), .rst_b(rst_b), .pin_in(sweep_ctl_pin), .level_out(trig_lvl));

   logic upd_prev_q;
   logic trig_prev_q;
   wire upd_pulse = upd_lvl && !upd_prev_q;
   wire trig_edge = trig_lvl && !trig_prev_q;

   // ---------------------------------------------------------------
   // shadow and active registers
   // ---------------------------------------------------------------
   logic [31:0] shadow_q;
   logic [31:0] active_q;
   logic [RATE_W-1:0] rate_shadow_q;
   logic [RATE_W-1:0] rate_active_q;
   logic rate_pending_q;

   // edge history resets low like the filtered levels, so reset itself makes no edge
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         upd_prev_q <= 1'b0;
         trig_prev_q <= 1'b0;
      end
      else
      begin
         upd_prev_q <= upd_lvl;
         trig_prev_q <= trig_lvl;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         shadow_q <= dds_ctl_pkg::ctl_reset;
         active_q <= dds_ctl_pkg::ctl_reset;
      end
      else
      begin
         if (wr_en)
            shadow_q <= wr_data;
         if (upd_pulse)
            active_q <= shadow_q;
      end
   end

   // ---------------------------------------------------------------
   // field decode
   // ---------------------------------------------------------------
   wire [1:0] dest_f = active_q[dds_ctl_pkg::dest_hi:dds_ctl_pkg::dest_lo];
   wire acc_en = active_q[dds_ctl_pkg::acc_en_bit];
   wire dc_bit = active_q[dds_ctl_pkg::dc_out_bit];
   wire state_mode = active_q[dds_ctl_pkg::state_trig_bit];
   wire no_dwell = active_q[dds_ctl_pkg::no_dwell_bit];
   wire full_pd_mode = active_q[dds_ctl_pkg::ext_pd_mode_bit];
   // auto-clear uses the value just transferred, so the strobe's own word governs it
   wire aclr_aux = shadow_q[dds_ctl_pkg::aclr_aux_bit];
   wire aclr_ph = shadow_q[dds_ctl_pkg::aclr_phase_bit];

   wire fast_pd = pd_lvl && !full_pd_mode;
   wire full_pd = pd_lvl && full_pd_mode;
   wire dig_off = active_q[dds_ctl_pkg::dig_pd_bit] || pd_lvl;
   wire dac_off = active_q[dds_ctl_pkg::dac_pd_bit] || full_pd;
   wire clk_off = active_q[dds_ctl_pkg::clk_pd_bit] || full_pd;
   wire trig_d = state_mode ? trig_lvl : trig_edge;
   wire fdest_d = acc_en && (dest_f == dds_ctl_pkg::dest_freq);
   wire pdest_d = acc_en && (dest_f == dds_ctl_pkg::dest_phase);

   // ---------------------------------------------------------------
   // sweep rate value handling
   // ---------------------------------------------------------------
   logic timer_tick;
   wire force_load = upd_pulse && shadow_q[dds_ctl_pkg::load_rate_bit];
   wire take_rate = force_load || (timer_tick && rate_pending_q);
   // a deferred value must be what the timer reloads at timeout, else the old rate runs one more period
   wire [RATE_W-1:0] reload_val = (force_load || rate_pending_q) ? rate_shadow_q : rate_active_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         rate_shadow_q <= dds_ctl_pkg::rate_reset[RATE_W-1:0];
         rate_active_q <= dds_ctl_pkg::rate_reset[RATE_W-1:0];
         rate_pending_q <= 1'b0;
      end
      else
      begin
         rate_shadow_q <= sweep_rate_value;
         if (take_rate)
            rate_active_q <= rate_shadow_q;
         if (upd_pulse && !shadow_q[dds_ctl_pkg::load_rate_bit])
            rate_pending_q <= 1'b1;
         else if (take_rate)
            rate_pending_q <= 1'b0;
      end
   end

   rate_timer #(.W(RATE_W)) u_timer
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .run(acc_en && !dig_off),
      .force_load(force_load),
      .rate(reload_val),
      .tick(timer_tick)
   );

   // ---------------------------------------------------------------
   // registered outputs: readback and active copy
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         rd_data <= dds_ctl_pkg::ctl_reset;
         active_word <= dds_ctl_pkg::ctl_reset;
      end
      else
      begin
         rd_data <= shadow_q;
         active_word <= active_q;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs: auxiliary accumulator and sweep
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         freq_dest <= 1'b0;
         phase_dest <= 1'b0;
         aux_acc_run <= 1'b0;
         dc_full_scale <= 1'b0;
         dds_out_off <= 1'b0;
         sweep_trigger <= 1'b0;
         sweep_to_start <= 1'b0;
         sweep_hold <= 1'b0;
         sine_sel <= 1'b0;
      end
      else
      begin
         freq_dest <= fdest_d;
         phase_dest <= pdest_d;
         aux_acc_run <= acc_en;
         dc_full_scale <= acc_en && dc_bit;
         dds_out_off <= acc_en && dc_bit;
         sweep_trigger <= acc_en && trig_d;
         sweep_to_start <= acc_en && sweep_done && no_dwell;
         sweep_hold <= acc_en && sweep_done && !no_dwell;
         sine_sel <= active_q[dds_ctl_pkg::sine_bit];
      end
   end

   // ---------------------------------------------------------------
   // registered outputs: power-down
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         digital_pd <= 1'b0;
         dac_digital_pd <= 1'b0;
         dac_pd <= 1'b0;
         pll_pd <= 1'b0;
         osc_pd <= 1'b0;
         clk_gen_stop <= 1'b0;
      end
      else
      begin
         digital_pd <= dig_off;
         dac_digital_pd <= fast_pd || full_pd;
         dac_pd <= dac_off;
         pll_pd <= full_pd;
         osc_pd <= clk_off;
         clk_gen_stop <= clk_off;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs: one-cycle pulses
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         rate_tick <= 1'b0;
         aux_acc_clear <= 1'b0;
         phase_acc_clear <= 1'b0;
      end
      else
      begin
         rate_tick <= timer_tick;
         aux_acc_clear <= upd_pulse && aclr_aux;
         phase_acc_clear <= upd_pulse && aclr_ph;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_shadow_transfer: assert property (@(posedge ref_clk) disable iff (!rst_b)
      upd_pulse |=> active_q == $past(shadow_q))
      else $error("active word not loaded on update");
   a_active_stable: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !upd_pulse |=> $stable(active_q))
      else $error("active word changed without update");
   a_aux_clear_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
      aux_acc_clear |=> !aux_acc_clear)
      else $error("aux clear longer than one cycle");
   a_phase_clear_cause: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (upd_pulse && aclr_ph) |=> phase_acc_clear ##1 !phase_acc_clear)
      else $error("phase clear not exactly one cycle");
   a_dc_gated: assert property (@(posedge ref_clk) disable iff (!rst_b)
      dc_full_scale |-> $past(acc_en))
      else $error("dc output without sweep enabled");
   a_acc_run: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !acc_en |=> !aux_acc_run && !freq_dest && !phase_dest)
      else $error("aux accumulator active while disabled");
   a_fast_pd: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (fast_pd && !active_q[dds_ctl_pkg::clk_pd_bit] && !active_q[dds_ctl_pkg::dac_pd_bit])
      |=> digital_pd && !pll_pd && !dac_pd && !osc_pd)
      else $error("fast power-down touched analog parts");
   a_full_pd: assert property (@(posedge ref_clk) disable iff (!rst_b)
      full_pd |=> pll_pd && dac_pd && digital_pd && clk_gen_stop)
      else $error("full power-down incomplete");
   a_sine_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
      sine_sel == $past(active_q[dds_ctl_pkg::sine_bit]))
      else $error("sine select mismatch");
   a_rate_force: assert property (@(posedge ref_clk) disable iff (!rst_b)
      force_load |=> rate_active_q == $past(rate_shadow_q))
      else $error("rate not loaded on update");
   a_dest_freq: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (acc_en && dest_f == dds_ctl_pkg::dest_freq) |=> freq_dest && !phase_dest)
      else $error("frequency destination not selected");
   a_dest_phase: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (acc_en && dest_f == dds_ctl_pkg::dest_phase) |=> phase_dest && !freq_dest)
      else $error("phase destination not selected");
   a_acc_on: assert property (@(posedge ref_clk) disable iff (!rst_b)
      acc_en |=> aux_acc_run)
      else $error("aux accumulator idle while enabled");
   a_dc_forced: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (acc_en && dc_bit) |=> dc_full_scale && dds_out_off)
      else $error("dc output not forced");
   a_trig_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (acc_en && state_mode) |=> sweep_trigger == $past(trig_lvl))
      else $error("level trigger mismatch");
   a_trig_edge: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (acc_en && !state_mode) |=> sweep_trigger == $past(trig_edge))
      else $error("edge trigger mismatch");
   a_dwell_choice: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (acc_en && sweep_done) |=> sweep_to_start == $past(no_dwell) && sweep_hold == !$past(no_dwell))
      else $error("sweep end behaviour mismatch");
   a_sweep_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !acc_en |=> !sweep_to_start && !sweep_hold && !sweep_trigger && !dc_full_scale)
      else $error("sweep controls active while disabled");
   a_digital_pd: assert property (@(posedge ref_clk) disable iff (!rst_b)
      active_q[dds_ctl_pkg::dig_pd_bit] |=> digital_pd)
      else $error("digital core not powered down");
   a_dac_pd: assert property (@(posedge ref_clk) disable iff (!rst_b)
      active_q[dds_ctl_pkg::dac_pd_bit] |=> dac_pd)
      else $error("converter not powered down");
   a_clock_stop: assert property (@(posedge ref_clk) disable iff (!rst_b)
      active_q[dds_ctl_pkg::clk_pd_bit] |=> clk_gen_stop && osc_pd)
      else $error("clock generation not stopped");
   a_rate_deferred: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (upd_pulse && !shadow_q[dds_ctl_pkg::load_rate_bit] && !timer_tick) |=> $stable(rate_active_q))
      else $error("deferred rate taken at update");
   a_rate_timeout: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (timer_tick && rate_pending_q && !upd_pulse) |=> !rate_pending_q && rate_active_q == $past(rate_shadow_q))
      else $error("deferred rate not taken at timeout");
   a_aux_clear_cause: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (upd_pulse && aclr_aux) |=> aux_acc_clear ##1 !aux_acc_clear)
      else $error("aux clear not exactly one cycle");
   a_clear_source: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !upd_pulse |=> !aux_acc_clear && !phase_acc_clear)
      else $error("accumulator clear without update");
   a_readback: assert property (@(posedge ref_clk) disable iff (!rst_b)
      wr_en |=> ##1 rd_data == $past(wr_data, 2))
      else $error("shadow readback mismatch");
endmodule : dds_ctl_word

// [dds_host_model.sv]
// host controller model: writes control word one and pulses the update pin
`timescale 1ns/1ps
module dds_host_model #(
   parameter int RATE_W = 16
)
(
   input wire logic ref_clk, // system clock
   output logic wr_en, // write strobe
   output logic [31:0] wr_data, // write data
   output logic [RATE_W-1:0] sweep_rate_value, // sweep rate value
   output logic io_update_pin // update strobe pin
);
   initial
   begin
      wr_en = 1'b0;
      wr_data = 32'h0000_0000;
      sweep_rate_value = 16'h0001;
      io_update_pin = 1'b0;
   end
   // ----------------------------------------
   // host cycles
   // ----------------------------------------
   // destination field is kept in 00/01 by the caller
   task automatic write_word(input logic [31:0] w);
      @(posedge ref_clk);
      #1 wr_en = 1'b1;
      wr_data = w;
      @(posedge ref_clk);
      #1 wr_en = 1'b0;
      // released data no longer shows the last word
      wr_data = ~w;
   endtask : write_word
   // pin high and low long enough to pass the input filter
   task automatic update();
      @(posedge ref_clk);
      #1 io_update_pin = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1 io_update_pin = 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask : update
   task automatic set_rate(input logic [RATE_W-1:0] r);
      @(posedge ref_clk);
      #1 sweep_rate_value = r;
   endtask : set_rate
endmodule : dds_host_model

// [dds_ctl_word_tb.sv]
// self-checking testbench for control word one
`timescale 1ns/1ps
module dds_ctl_word_tb;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic pd_pin = 1'b0;
   logic sw_pin = 1'b0;
   logic sw_done = 1'b0;
   logic wr_en, io_upd;
   logic [31:0] wr_data, rd_data, active_word;
   logic [15:0] rate_val;
   logic freq_dest, phase_dest, aux_acc_run, dc_full_scale, dds_out_off, sweep_trigger;
   logic sweep_to_start, sweep_hold, digital_pd, dac_digital_pd, dac_pd, pll_pd, osc_pd;
   logic clk_gen_stop, rate_tick, aux_acc_clear, phase_acc_clear, sine_sel;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int aux_n = 0;
   int ph_n = 0;
   int trg_n = 0;
   int tk_n = 0;
   logic [31:0] w;
   always #2.5 ref_clk = ~ref_clk;
   dds_host_model #(.RATE_W(16)) host (.ref_clk(ref_clk), .wr_en(wr_en), .wr_data(wr_data),
      .sweep_rate_value(rate_val), .io_update_pin(io_upd));
   dds_ctl_word #(.RATE_W(16)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .wr_en(wr_en), .wr_data(wr_data),
      .rd_data(rd_data), .sweep_rate_value(rate_val), .io_update_pin(io_upd),
      .external_powerdown_pin(pd_pin), .sweep_ctl_pin(sw_pin), .sweep_done(sw_done),
      .active_word(active_word), .freq_dest(freq_dest), .phase_dest(phase_dest),
      .aux_acc_run(aux_acc_run), .dc_full_scale(dc_full_scale), .dds_out_off(dds_out_off),
      .sweep_trigger(sweep_trigger), .sweep_to_start(sweep_to_start), .sweep_hold(sweep_hold),
      .digital_pd(digital_pd), .dac_digital_pd(dac_digital_pd), .dac_pd(dac_pd), .pll_pd(pll_pd),
      .osc_pd(osc_pd), .clk_gen_stop(clk_gen_stop), .rate_tick(rate_tick),
      .aux_acc_clear(aux_acc_clear), .phase_acc_clear(phase_acc_clear), .sine_sel(sine_sel));
   // ----------------------------------------
   // pulse counters and hang guard
   // ----------------------------------------
   always @(posedge ref_clk)
   begin
      aux_n += (aux_acc_clear === 1'b1);
      ph_n += (phase_acc_clear === 1'b1);
      trg_n += (sweep_trigger === 1'b1);
      tk_n += (rate_tick === 1'b1);
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // ----------------------------------------
   // write, update, compare every decoded output except sweep_trigger and rate_tick
   // ----------------------------------------
   task automatic apply(input logic [31:0] wd, input logic pd);
      logic ful;
      ful = pd & wd[7];
      pd_pin = pd;
      host.write_word(wd);
      repeat (2) @(posedge ref_clk);
      #1 chk(rd_data, wd, "readback");
      aux_n = 0;
      ph_n = 0;
      host.update();
      #1 chk(active_word, wd, "active word");
      chk({freq_dest, phase_dest}, {wd[11] & (wd[13:12] == 2'h0), wd[11] & (wd[13:12] == 2'h1)}, "dest");
      chk(aux_acc_run, wd[11], "aux run");
      chk({dc_full_scale, dds_out_off}, {2{wd[11] & wd[10]}}, "dc out");
      chk({sweep_to_start, sweep_hold}, {wd[11] & wd[8], wd[11] & ~wd[8]}, "dwell");
      chk(digital_pd, wd[6] | pd, "digital pd");
      chk({dac_digital_pd, dac_pd}, {pd, wd[5] | ful}, "dac pd");
      chk({pll_pd, osc_pd}, {ful, wd[4] | ful}, "pll osc pd");
      chk(clk_gen_stop, wd[4] | ful, "clock stop");
      chk(sine_sel, wd[0], "sine");
      chk(aux_n, {31'h0, wd[2]}, "aux clear pulses");
      chk(ph_n, {31'h0, wd[1]}, "phase clear pulses");
   endtask : apply
   initial
   begin
      void'($urandom(32'h61604480));
      repeat (8) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      @(posedge ref_clk);
      #1 chk(active_word, 32'h0000_0000, "reset word");
      chk(rd_data, 32'h0000_0000, "reset readback");
      // write without update must not reach the active copy
      host.write_word(32'h0000_0FFF);
      repeat (4) @(posedge ref_clk);
      #1 chk(active_word, 32'h0000_0000, "no update");
      $display("test reset and shadow done");
      sw_done = 1'b1;
      apply(32'h0000_0080, 1'b1);
      apply(32'h0000_0000, 1'b1);
      apply(32'h0000_3FFF & ~32'h0000_2000, 1'b0);
      $display("test corner words done");
      for (int i = 0; i < 24; i++)
      begin
         w = $urandom;
         w[13] = 1'b0;
         host.set_rate(w[31:16]);
         apply(w, 1'($urandom % 2));
      end
      $display("test random words done");
      // level trigger follows the pin, edge trigger only pulses
      for (int m = 0; m < 2; m++)
      begin
         sw_pin = 1'b0;
         apply(32'h0000_0800 | (m << 9), 1'b0);
         trg_n = 0;
         sw_pin = 1'b1;
         repeat (14) @(posedge ref_clk);
         #1 chk(sweep_trigger, m[0], "trigger level");
         chk(trg_n > 0, 1'b1, "trigger seen");
      end
      $display("test trigger modes done");
      // rate reload: at once when bit 3 is set, else at the running count's timeout
      host.set_rate(16'h0190);
      apply(32'h0000_0808, 1'b0);
      host.set_rate(16'h000A);
      apply(32'h0000_0808, 1'b0);
      tk_n = 0;
      repeat (40) @(posedge ref_clk);
      #1 chk(tk_n >= 2, 1'b1, "rate loaded at update");
      host.set_rate(16'h0190);
      apply(32'h0000_0808, 1'b0);
      host.set_rate(16'h000A);
      apply(32'h0000_0800, 1'b0);
      tk_n = 0;
      repeat (40) @(posedge ref_clk);
      #1 chk(tk_n, 32'h0000_0000, "rate kept until timeout");
      repeat (400) @(posedge ref_clk);
      tk_n = 0;
      repeat (40) @(posedge ref_clk);
      #1 chk(tk_n >= 2, 1'b1, "rate loaded at timeout");
      $display("test rate reload done");
      test_done();
   end
endmodule : dds_ctl_word_tb
